// file: common/l2_ctrl_pkg.sv
// Functional notes
// R01 - slow tap lengthens every DLL tap delay
// R02 - software keeps slow tap zero here
// R03 - differential clock mode stays zero here
// R04 - bypass bit reserved, written as zero
// R05 - two spare bits stored, kept zero
// R06 - instr_only: data hits served, misses bypass
// R07 - both restrictions set locks the cache
// R08 - instr_only may change at any time
// R09 - clock stop gates both sram clocks
// R10 - feedback loop keeps running while gated
// R11 - rollover stop raises processor checkstop
// R12 - last tap counts as potential rollover
// R13 - read-only DLL counter, 0 to 127
// R14 - software reads counter until stable
// R15 - read-only invalidate in progress flag
// R16 - zero ratio stops clock and DLL
// R17 - global invalidate clears all status entries
// R18 - in progress until every entry cleared
package l2_ctrl_pkg;

    ////////////////////////////////////////////////////////////////////////////////
    // register map, byte addresses
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_IRQ_STATUS = 8'h04;
    localparam logic [7:0] ADDR_IRQ_MASK = 8'h08;
    localparam logic [7:0] ADDR_DLL_STATUS = 8'h0c;

    // control word fields; documented bit n sits at hardware bit 31-n
    localparam int BIT_ENABLE = 31;
    localparam int RATIO_HI = 27;
    localparam int RATIO_LO = 25;
    localparam int BIT_DATA_ONLY = 22;
    localparam int BIT_INVALIDATE = 21;
    localparam int BIT_SLOW_TAP = 15;
    localparam int BIT_DIFF_CLOCK = 14;
    localparam int BIT_BYPASS = 13;
    localparam int BIT_INSTR_ONLY = 10;
    localparam int BIT_CLOCK_STOP = 9;
    localparam int BIT_ROLL_STOP = 8;
    localparam int CTR_HI = 7;
    localparam int CTR_LO = 1;
    localparam int BIT_IN_PROGRESS = 0;
    localparam logic [31:0] CTRL_WRITE_MASK = 32'hffff_ff00;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;

    // clock ratio codes
    localparam logic [2:0] RATIO_OFF = 3'h0;
    localparam logic [2:0] RATIO_DIV1 = 3'h1;
    localparam logic [2:0] RATIO_DIV1P5 = 3'h2;
    localparam logic [2:0] RATIO_DIV2 = 3'h4;
    localparam logic [2:0] RATIO_DIV2P5 = 3'h5;
    localparam logic [2:0] RATIO_DIV3 = 3'h6;

    // interrupt status bits
    localparam int IRQ_W = 3;
    localparam int IRQ_INVAL_DONE = 0;
    localparam int IRQ_ROLLOVER = 1;
    localparam int IRQ_DLL_LOCK = 2;

    // timing
    localparam int CLK_MHZ = 250;
    localparam int DLL_SETTLE_NS = 1000;
    localparam int SETTLE_CYCLES = (DLL_SETTLE_NS * CLK_MHZ + 999) / 1000;
    localparam int DLL_ADJUST_NS = 40;
    localparam int ADJUST_CYCLES = (DLL_ADJUST_NS * CLK_MHZ) / 1000;

    typedef enum logic [0:0] {INV_IDLE, INV_SWEEP} inval_state_t;

    typedef struct packed {
        logic valid;
        logic instr;
        logic write;
        logic hit;
    } acc_req_t;

    typedef struct packed {
        logic valid;
        logic use_l2;
        logic allocate;
        logic bypass;
    } acc_rsp_t;

    // sram clock period in ref cycles per ratio code, zero means stopped
    function automatic logic [2:0] ratio_period(input logic [2:0] code);
        case (code)
            RATIO_DIV1: ratio_period = 3'h2;
            RATIO_DIV1P5: ratio_period = 3'h3;
            RATIO_DIV2: ratio_period = 3'h4;
            RATIO_DIV2P5: ratio_period = 3'h5;
            RATIO_DIV3: ratio_period = 3'h6;
            default: ratio_period = 3'h0;
        endcase
    endfunction

endpackage

// file: src/l2_cache_dll_ctrl.sv
`timescale 1ns/100ps
module l2_cache_dll_ctrl import l2_ctrl_pkg::*; #(
    parameter int NUM_ENTRIES = 8192,
    parameter int CTR_W = 7
) (
    // clock and reset
    input wire logic i_ref_clk,
    input wire logic i_nrst,
    // apb slave
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [7:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    // cache access policy
    input wire acc_req_t i_acc,
    output acc_rsp_t o_rsp,
    // power mode pins
    input wire logic i_nap,
    input wire logic i_sleep,
    input wire logic i_snoop_wake,
    // dll phase detector
    input wire logic i_phase_early,
    input wire logic i_phase_late,
    output logic [CTR_W-1:0] o_dll_tap,
    output logic o_dll_slow_tap,
    output logic o_diff_clock_mode,
    // sram clocks
    output logic [1:0] o_sram_clock_out,
    output logic o_dll_feedback_out,
    // status array clearing
    output logic o_tag_clear_valid,
    output logic [$clog2(NUM_ENTRIES)-1:0] o_tag_clear_index,
    // checkstop and interrupt
    output logic o_checkstop,
    output logic o_irq
);

    localparam int IDX_W = $clog2(NUM_ENTRIES);
    localparam logic [IDX_W-1:0] LAST_IDX = IDX_W'(NUM_ENTRIES - 1);
    localparam logic [CTR_W-1:0] LAST_TAP = {CTR_W{1'b1}};
    localparam logic [8:0] SETTLE_MAX = 9'(SETTLE_CYCLES);
    localparam logic [3:0] ADJUST_MAX = 4'(ADJUST_CYCLES - 1);
    localparam int SYNC_W = 5;

    typedef struct packed {
        logic [SYNC_W-1:0] sync1;
        logic [SYNC_W-1:0] sync2;
        logic [31:0] ctrl;
        logic [IRQ_W-1:0] irq_status;
        logic [IRQ_W-1:0] irq_mask;
        logic [31:0] prdata;
        logic slverr;
        logic [CTR_W-1:0] ctr;
        logic [3:0] adj_cnt;
        logic [8:0] settle_cnt;
        logic locked;
        inval_state_t inval;
        logic [IDX_W-1:0] inval_idx;
        logic [2:0] div_cnt;
        logic [1:0] sram_clk;
        logic fb_out;
        logic checkstop;
        acc_rsp_t rsp;
    } state_t;

    logic [1:0] rst_sync;
    logic rst_n;
    state_t st;
    state_t next_st;

    ////////////////////////////////////////////////////////////////////////////////
    // reset release through two flops
    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            rst_sync <= 2'h0;
        end else begin
            rst_sync <= {rst_sync[0], 1'b1};
        end
    end
    assign rst_n = rst_sync[1];

    ////////////////////////////////////////////////////////////////////////////////
    // decoded views of the control word
    logic [2:0] ratio;
    logic [2:0] period;
    logic dll_on;
    logic setup;
    logic wr_access;
    logic [IRQ_W-1:0] events;
    logic low_power;
    logic early;
    logic late;
    logic adjust_tick;
    logic mapped;
    logic restricted;
    logic cache_on;

    assign ratio = st.ctrl[RATIO_HI:RATIO_LO];
    assign period = ratio_period(ratio);
    assign dll_on = (period != 3'h0); // R16
    assign setup = i_psel && !i_penable;
    assign wr_access = i_psel && i_penable && i_pwrite;
    assign mapped = (i_paddr == ADDR_CTRL) || (i_paddr == ADDR_IRQ_STATUS) ||
                    (i_paddr == ADDR_IRQ_MASK) || (i_paddr == ADDR_DLL_STATUS);
    // synchronised pins: nap, sleep, snoop, early, late
    assign low_power = (st.sync2[0] || st.sync2[1]) && !st.sync2[2];
    assign early = st.sync2[3];
    assign late = st.sync2[4];
    assign adjust_tick = (st.adj_cnt == ADJUST_MAX);
    assign cache_on = st.ctrl[BIT_ENABLE];
    // instruction side obeys data_only, data side obeys instr_only
    assign restricted = i_acc.instr ? st.ctrl[BIT_DATA_ONLY] : st.ctrl[BIT_INSTR_ONLY];

    ////////////////////////////////////////////////////////////////////////////////
    // next state
    always_comb begin
        next_st = st;
        events = '0;
        next_st.sync1 = {i_phase_late, i_phase_early, i_snoop_wake, i_sleep, i_nap};
        next_st.sync2 = st.sync1;

        // apb read data captured in the setup cycle, so the counter
        // sample is the value at the moment of the read
        if (setup) begin
            next_st.slverr = !mapped;
            case (i_paddr)
                ADDR_CTRL: begin
                    next_st.prdata = st.ctrl;
                    next_st.prdata[CTR_HI:CTR_LO] = st.ctr; // R13
                    next_st.prdata[BIT_IN_PROGRESS] = (st.inval == INV_SWEEP); // R15
                end
                ADDR_IRQ_STATUS: next_st.prdata = 32'(st.irq_status);
                ADDR_IRQ_MASK: next_st.prdata = 32'(st.irq_mask);
                ADDR_DLL_STATUS: next_st.prdata = {31'h0, st.locked};
                default: next_st.prdata = 32'h0;
            endcase
        end

        // control writes; stored bits include the reserved ones
        if (wr_access && i_paddr == ADDR_CTRL) begin
            next_st.ctrl = (i_pwdata & CTRL_WRITE_MASK) | (st.ctrl & ~CTRL_WRITE_MASK); // R05 R08
        end
        if (wr_access && i_paddr == ADDR_IRQ_MASK) begin
            next_st.irq_mask = i_pwdata[IRQ_W-1:0];
        end

        // global invalidate sweep over every status entry
        case (st.inval)
            INV_IDLE: begin
                if (wr_access && i_paddr == ADDR_CTRL && i_pwdata[BIT_INVALIDATE]) begin
                    next_st.inval = INV_SWEEP; // R17 R18
                    next_st.inval_idx = '0;
                end
            end
            INV_SWEEP: begin
                if (st.inval_idx == LAST_IDX) begin
                    next_st.inval = INV_IDLE; // R18
                    events[IRQ_INVAL_DONE] = 1'b1;
                end else begin
                    next_st.inval_idx = st.inval_idx + 1'b1; // R17
                end
            end
            default: next_st.inval = INV_IDLE;
        endcase

        // dll: counter walks toward phase lock, held at zero when disabled
        if (!dll_on) begin
            next_st.ctr = '0; // R16
            next_st.adj_cnt = 4'h0;
            next_st.settle_cnt = 9'h0;
            next_st.locked = 1'b0;
        end else begin
            next_st.adj_cnt = adjust_tick ? 4'h0 : st.adj_cnt + 1'b1;
            if (st.settle_cnt != SETTLE_MAX) begin
                next_st.settle_cnt = st.settle_cnt + 1'b1;
            end else if (!st.locked) begin
                next_st.locked = 1'b1;
                events[IRQ_DLL_LOCK] = 1'b1;
            end
            if (adjust_tick && late && !early) begin
                next_st.ctr = st.ctr + 1'b1; // wraps past the last tap
                if (st.ctr == LAST_TAP) begin
                    events[IRQ_ROLLOVER] = 1'b1;
                end
            end else if (adjust_tick && early && !late && st.ctr != '0) begin
                next_st.ctr = st.ctr - 1'b1;
            end
        end
        // a new ratio restarts settling; placed after the loop so it wins
        if (wr_access && i_paddr == ADDR_CTRL && i_pwdata[RATIO_HI:RATIO_LO] != ratio) begin
            next_st.settle_cnt = 9'h0; // R16
            next_st.locked = 1'b0;
        end
        // sitting on the last tap already counts as rollover
        if (dll_on && st.ctr == LAST_TAP) begin
            events[IRQ_ROLLOVER] = 1'b1; // R12
        end
        // checkstop stays until reset: the core is halted anyway
        if (st.ctrl[BIT_ROLL_STOP] && events[IRQ_ROLLOVER]) begin
            next_st.checkstop = 1'b1; // R11
        end

        // sram clock divider; feedback path stops only when the dll is off, never for clock stop
        if (!dll_on || st.div_cnt >= period - 3'h1) begin
            next_st.div_cnt = 3'h0;
        end else begin
            next_st.div_cnt = st.div_cnt + 1'b1;
        end
        next_st.fb_out = dll_on && ({st.div_cnt, 1'b0} < {1'b0, period}); // R10 R16
        if (st.ctrl[BIT_CLOCK_STOP] && low_power) begin
            next_st.sram_clk = 2'h0; // R09
        end else begin
            next_st.sram_clk = {2{next_st.fb_out}}; // R09
        end

        // access policy, one cycle after the request
        next_st.rsp.valid = i_acc.valid;
        next_st.rsp.use_l2 = i_acc.valid && cache_on && i_acc.hit; // R06 R07
        next_st.rsp.allocate = i_acc.valid && cache_on && !i_acc.hit && !restricted; // R07
        next_st.rsp.bypass = i_acc.valid && !(cache_on && (i_acc.hit || !restricted)); // R06

        // sticky status: a new event beats a write-one clear
        if (wr_access && i_paddr == ADDR_IRQ_STATUS) begin
            next_st.irq_status = st.irq_status & ~i_pwdata[IRQ_W-1:0];
        end
        next_st.irq_status = next_st.irq_status | events;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // state register
    always_ff @(posedge i_ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            st <= '0;
            st.ctrl <= CTRL_RESET;
            st.inval <= INV_IDLE;
        end else begin
            st <= next_st;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // outputs
    assign o_prdata = st.prdata;
    assign o_pready = i_psel && i_penable; // zero wait states
    assign o_pslverr = i_psel && i_penable && st.slverr;
    assign o_rsp = st.rsp;
    assign o_dll_tap = st.ctr;
    assign o_dll_slow_tap = st.ctrl[BIT_SLOW_TAP]; // R01
    assign o_diff_clock_mode = st.ctrl[BIT_DIFF_CLOCK]; // R03
    assign o_sram_clock_out = st.sram_clk;
    assign o_dll_feedback_out = st.fb_out;
    assign o_tag_clear_valid = (st.inval == INV_SWEEP);
    assign o_tag_clear_index = st.inval_idx;
    assign o_checkstop = st.checkstop;
    assign o_irq = |(st.irq_status & st.irq_mask);

    ////////////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!rst_n);

    a_slow_tap_out: assert property ( // R01
        wr_access && i_paddr == ADDR_CTRL |=> o_dll_slow_tap == $past(i_pwdata[BIT_SLOW_TAP]))
        else $error("slow tap output does not follow written bit");

    a_diff_clock_out: assert property ( // R03
        wr_access && i_paddr == ADDR_CTRL |=> o_diff_clock_mode == $past(i_pwdata[BIT_DIFF_CLOCK]))
        else $error("differential clock output does not follow written bit");

    a_spare_bits_kept: assert property ( // R05
        wr_access && i_paddr == ADDR_CTRL |=> st.ctrl[12:11] == $past(i_pwdata[12:11]))
        else $error("spare bits not stored");

    a_data_miss_bypass: assert property ( // R06
        i_acc.valid && !i_acc.instr && !i_acc.hit && st.ctrl[BIT_INSTR_ONLY]
        |=> o_rsp.bypass && !o_rsp.allocate)
        else $error("data miss under instr_only did not bypass");

    a_hit_served: assert property ( // R06
        i_acc.valid && i_acc.hit && cache_on |=> o_rsp.use_l2 && !o_rsp.bypass)
        else $error("hit in enabled cache not served");

    a_locked_no_alloc: assert property ( // R07
        st.ctrl[BIT_INSTR_ONLY] && st.ctrl[BIT_DATA_ONLY] && i_acc.valid |=> !o_rsp.allocate)
        else $error("locked cache allocated a line");

    a_clock_gated: assert property ( // R09
        st.ctrl[BIT_CLOCK_STOP] && low_power |=> o_sram_clock_out == 2'h0)
        else $error("sram clocks not gated in low power");

    a_feedback_runs: assert property ( // R10
        dll_on && o_dll_feedback_out |-> ##[1:6] !o_dll_feedback_out)
        else $error("feedback clock stalled");

    a_rollover_stop: assert property ( // R11 R12
        st.ctrl[BIT_ROLL_STOP] && dll_on && st.ctr == LAST_TAP |=> o_checkstop)
        else $error("last tap did not raise checkstop");

    a_counter_read: assert property ( // R13
        setup && i_paddr == ADDR_CTRL ##1 i_psel && i_penable
        |-> o_prdata[CTR_HI:CTR_LO] == $past(st.ctr))
        else $error("counter field does not show sampled counter");

    a_dll_off: assert property ( // R16
        !dll_on |=> o_dll_tap == '0 && !o_dll_feedback_out)
        else $error("zero ratio left dll running");

    a_inval_busy: assert property ( // R15 R18
        st.inval == INV_IDLE && wr_access && i_paddr == ADDR_CTRL && i_pwdata[BIT_INVALIDATE]
        |=> o_tag_clear_valid && o_tag_clear_index == '0)
        else $error("invalidate did not start sweep at entry zero");

    a_inval_end: assert property ( // R17 R18
        o_tag_clear_valid && o_tag_clear_index == LAST_IDX
        |=> !o_tag_clear_valid && st.irq_status[IRQ_INVAL_DONE])
        else $error("sweep did not end after last entry");

    a_progress_flag_read: assert property ( // R15
        setup && i_paddr == ADDR_CTRL ##1 i_psel && i_penable
        |-> o_prdata[BIT_IN_PROGRESS] == $past(st.inval == INV_SWEEP))
        else $error("in progress flag does not show sweep state");

    a_ratio_unlocks: assert property ( // R16
        wr_access && i_paddr == ADDR_CTRL && i_pwdata[RATIO_HI:RATIO_LO] != ratio |=> !st.locked)
        else $error("ratio change did not restart dll settling");

    a_checkstop_held: assert property ( // R11
        o_checkstop |=> o_checkstop)
        else $error("checkstop dropped before reset");

    a_clock_running: assert property ( // R09
        !(st.ctrl[BIT_CLOCK_STOP] && low_power)
        |=> o_sram_clock_out == {2{o_dll_feedback_out}})
        else $error("sram clocks not restarted");

    a_rollover_event: assert property ( // R12
        dll_on && st.ctr == LAST_TAP |=> st.irq_status[IRQ_ROLLOVER])
        else $error("last tap did not flag rollover");

    a_data_write_hit: assert property ( // R06
        i_acc.valid && !i_acc.instr && i_acc.write && i_acc.hit && cache_on
        && st.ctrl[BIT_INSTR_ONLY] |=> o_rsp.use_l2)
        else $error("data write hit under instr_only not served");

endmodule

// file: testbench/l2_sram_side_model.sv
`timescale 1ns/100ps
// far side of the delay loop: phase of the returned feedback clock
module l2_sram_side_model (
    // clock and reset
    input wire logic i_ref_clk,
    input wire logic i_nrst,
    // commanded phase error: 0 none, 1 late, 2 early
    input wire logic [1:0] i_mode,
    // feedback clock coming back
    input wire logic i_feedback,
    // phase detector
    output logic o_phase_early,
    output logic o_phase_late
);
    logic last_fb;
    // phase is only known while the loop runs, so it updates on feedback edges
    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            last_fb <= 1'b0;
            o_phase_early <= 1'b0;
            o_phase_late <= 1'b0;
        end else begin
            last_fb <= i_feedback;
            if (i_feedback && !last_fb) begin
                o_phase_late <= (i_mode == 2'h1);
                o_phase_early <= (i_mode == 2'h2);
            end
        end
    end
endmodule

// file: testbench/test_l2_cache_dll_ctrl.sv
`timescale 1ns/100ps
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin miscompares++; \
    $display("MISMATCH t=%0t got %h exp %h", $time, (g), (e)); end end
module test_l2_cache_dll_ctrl import l2_ctrl_pkg::*; ();
    localparam int N = 16;
    logic clk = 1'b0, nrst = 1'b0, psel = 1'b0, pen = 1'b0, pwr = 1'b0;
    logic nap = 1'b0, slp = 1'b0, wake = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, rd = 32'h0, seed = 32'd43209;
    logic [1:0] mode = 2'h0;
    acc_req_t acc = '0;
    logic [31:0] prdata;
    logic pready, pslverr, slow, diff, fb, clrv, ckstp, irq, early, late;
    acc_rsp_t rsp;
    logic [6:0] tap;
    logic [1:0] sclk;
    logic [3:0] clri;
    logic [32:0] rdq[$];
    logic [32:0] rdm[$];
    acc_rsp_t rspq[$];
    int miscompares = 0, tests_run = 0, clr_cnt = 0;
    logic [32:0] rexp, rmsk;
    acc_rsp_t rspe;
    logic [2:0] codes[5] = '{RATIO_DIV1, RATIO_DIV1P5, RATIO_DIV2, RATIO_DIV2P5, RATIO_DIV3};
    int per[5] = '{2, 3, 4, 5, 6};
    logic [2:0] gate[4] = '{3'b100, 3'b101, 3'b010, 3'b000};

    always #2 clk = ~clk;

    l2_cache_dll_ctrl #(.NUM_ENTRIES(N), .CTR_W(7)) u_l2_cache_dll_ctrl (
        .i_ref_clk(clk), .i_nrst(nrst), .i_psel(psel), .i_penable(pen), .i_pwrite(pwr),
        .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
        .o_pslverr(pslverr), .i_acc(acc), .o_rsp(rsp), .i_nap(nap), .i_sleep(slp),
        .i_snoop_wake(wake), .i_phase_early(early), .i_phase_late(late), .o_dll_tap(tap),
        .o_dll_slow_tap(slow), .o_diff_clock_mode(diff), .o_sram_clock_out(sclk),
        .o_dll_feedback_out(fb), .o_tag_clear_valid(clrv), .o_tag_clear_index(clri),
        .o_checkstop(ckstp), .o_irq(irq));

    l2_sram_side_model u_l2_sram_side_model (.i_ref_clk(clk), .i_nrst(nrst), .i_mode(mode),
        .i_feedback(fb), .o_phase_early(early), .o_phase_late(late));

    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction

    // apb master: request held until pready is sampled high
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwr <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        pen <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata;
        psel <= 1'b0;
        pen <= 1'b0;
    endtask

    // read with a note of {error, data} expected under a mask
    task automatic rd_exp(input logic [7:0] a, input logic [32:0] e, input logic [32:0] m);
        rdq.push_back(e & m);
        rdm.push_back(m);
        apb(1'b0, a, 32'h0);
    endtask

    task automatic rises(input int n, output int cs, output int cf);
        logic ps, pf;
        ps = sclk[0];
        pf = fb;
        cs = 0;
        cf = 0;
        repeat (n) begin
            @(posedge clk);
            cs += int'(sclk[0] & !ps);
            cf += int'(fb & !pf);
            ps = sclk[0];
            pf = fb;
        end
    endtask

    task automatic end_sim();
        $display("tests_run %0d miscompares %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // monitors take the oldest note as each result shows
    // notes are taken off first, so a mismatch report cannot pop twice
    always @(posedge clk) if (psel && pen && pready && !pwr) begin
        rmsk = rdm.pop_front();
        rexp = rdq.pop_front();
        `CHK({pslverr, prdata} & rmsk, rexp)
    end
    always @(posedge clk) if (rsp.valid === 1'b1) begin
        rspe = rspq.pop_front();
        `CHK(rsp, rspe)
    end
    // sweep must walk every entry in order
    always @(posedge clk) if (clrv === 1'b1) begin
        `CHK(clri, 4'(clr_cnt))
        clr_cnt++;
    end
    // a hang counts as a mismatch
    initial begin
        #80000;
        miscompares++;
        end_sim();
    end

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        int cs, cf;
        logic [31:0] prev;
        logic restr;
        repeat (5) @(posedge clk);
        nrst <= 1'b1;
        repeat (3) @(posedge clk);
        // reset values, then an unmapped place
        for (int k = 0; k < 4; k++) rd_exp(8'(4 * k), 33'h0, 33'h1_ffff_ffff);
        rd_exp(8'h10, 33'h1_0000_0000, 33'h1_ffff_ffff);
        $display("test reset values done");
        // stored option bits reach their pins and read back
        apb(1'b1, ADDR_CTRL, (32'h1 << BIT_SLOW_TAP) | (32'h1 << BIT_DIFF_CLOCK) | 32'h1800);
        @(posedge clk);
        `CHK({slow, diff}, 2'b11)
        rd_exp(ADDR_CTRL, 33'h0000_d800, 33'h0_ffff_ff00);
        apb(1'b1, ADDR_CTRL, 32'h0);
        @(posedge clk);
        `CHK({slow, diff}, 2'b00)
        $display("test option bits done");
        // global invalidate, in-progress flag and its interrupt
        apb(1'b1, ADDR_CTRL, 32'h1 << BIT_INVALIDATE);
        rd_exp(ADDR_CTRL, 33'h1, 33'h1);
        repeat (24) @(posedge clk);
        `CHK(clr_cnt, N)
        rd_exp(ADDR_CTRL, 33'h0, 33'h1);
        rd_exp(ADDR_IRQ_STATUS, 33'h1, 33'h1);
        `CHK(irq, 1'b0)
        apb(1'b1, ADDR_IRQ_MASK, 32'h1);
        @(posedge clk);
        `CHK(irq, 1'b1)
        apb(1'b1, ADDR_IRQ_STATUS, 32'h1);
        @(posedge clk);
        `CHK(irq, 1'b0)
        $display("test invalidate done");
        // every ratio code sets its clock rate, zero stops clock and loop
        foreach (codes[i]) begin
            apb(1'b1, ADDR_CTRL, 32'(codes[i]) << RATIO_LO);
            repeat (8) @(posedge clk);
            rises(60, cs, cf);
            `CHK(cs inside {[60 / per[i] - 1 : 60 / per[i] + 1]}, 1'b1)
        end
        apb(1'b1, ADDR_CTRL, 32'h0);
        repeat (8) @(posedge clk);
        rises(40, cs, cf);
        `CHK({cs, cf, tap}, {32'h0, 32'h0, 7'h0})
        $display("test clock ratios done");
        // gating in nap and sleep, snoop wake restarts, feedback keeps running
        apb(1'b1, ADDR_CTRL, (32'(RATIO_DIV2) << RATIO_LO) | (32'h1 << BIT_CLOCK_STOP));
        for (int k = 0; k < 4; k++) begin
            {nap, slp, wake} <= gate[k];
            repeat (8) @(posedge clk);
            rises(40, cs, cf);
            `CHK(cs inside {[9:11]}, 1'(k % 2))
            `CHK(cf inside {[9:11]}, 1'b1)
        end
        $display("test clock stop done");
        // lock, then access policy in every mode, changed while enabled
        apb(1'b1, ADDR_CTRL, (32'(RATIO_DIV2) << RATIO_LO) | (32'h1 << BIT_ENABLE));
        repeat (300) @(posedge clk);
        rd_exp(ADDR_DLL_STATUS, 33'h1, 33'h1);
        rd_exp(ADDR_IRQ_STATUS, 33'h4, 33'h4);
        for (int c = 0; c < 8; c++) begin
            apb(1'b1, ADDR_CTRL, (32'(RATIO_DIV2) << RATIO_LO) | (32'(c[2]) << BIT_ENABLE)
                | (32'(c[1]) << BIT_INSTR_ONLY) | (32'(c[0]) << BIT_DATA_ONLY));
            repeat (8) begin
                @(posedge clk);
                seed = xs(seed);
                acc <= {1'b1, seed[2:0]};
                restr = seed[2] ? c[0] : c[1];
                rspq.push_back({1'b1, c[2] & seed[0], c[2] & !seed[0] & !restr,
                    !c[2] | (!seed[0] & restr)});
            end
            @(posedge clk);
            acc <= '0;
        end
        $display("test access policy done");
        // last tap raises checkstop before any wrap
        apb(1'b1, ADDR_CTRL, (32'(RATIO_DIV1) << RATIO_LO) | (32'h1 << BIT_ROLL_STOP));
        `CHK(ckstp, 1'b0)
        mode <= 2'h1;
        repeat (3000) begin
            @(posedge clk);
            if (tap === 7'h7f) break;
        end
        mode <= 2'h0;
        repeat (4) @(posedge clk);
        `CHK(ckstp, 1'b1)
        do begin
            prev = rd;
            rd_exp(ADDR_CTRL, 33'h0, 33'h0);
        end while (rd !== prev);
        `CHK(rd[CTR_HI:CTR_LO], 7'h7f)
        rd_exp(ADDR_IRQ_STATUS, 33'h2, 33'h2);
        mode <= 2'h2;
        repeat (60) @(posedge clk);
        `CHK(tap < 7'h7f, 1'b1)
        // second reset clears the sticky checkstop
        nrst <= 1'b0;
        repeat (2) @(posedge clk);
        `CHK(ckstp, 1'b0)
        nrst <= 1'b1;
        mode <= 2'h0;
        repeat (3) @(posedge clk);
        rd_exp(ADDR_CTRL, 33'h0, 33'h1_ffff_ffff);
        $display("test rollover done");
        end_sim();
    end
endmodule
